// [rtl/ddim_consts.svh]
/*
 Constants of the disk data integrity manager: register offsets, field positions,
 reset values and ECC geometry. Assumes inclusion by the design, checker and bench top files.
*/
`ifndef DDIM_CONSTS_SVH
`define DDIM_CONSTS_SVH
`define DDIM_ECC_BYTES 52
`define DDIM_CHECK_BYTES 4
`define DDIM_RS_BYTES 48
`define DDIM_RS_PER_ILV 12
`define DDIM_ILV_COUNT 4
`define DDIM_MAX_ERR_ILV 3'h5
`define DDIM_MAX_ERR_SECTOR 5'h14
`define DDIM_PAT_ZERO 8'h00
`define DDIM_PAT_ONE 8'hFF
`define DDIM_BUF_AW 8
`define DDIM_BUF_LAST 8'hFF
`define DDIM_CAND_N 8
`define DDIM_CAND_IW 3
`define DDIM_RETRY_MAX 4'h3
`define DDIM_OFF_CTRL 12'h000
`define DDIM_OFF_STATUS 12'h004
`define DDIM_OFF_ECCERR 12'h008
`define DDIM_OFF_LBA 12'h00C
`define DDIM_OFF_CMD 12'h010
`define DDIM_OFF_CNT 12'h014
`define DDIM_CTRL_RESET 32'h0000_0001
`define DDIM_CTRL_WCE 0
`define DDIM_CTRL_SELFTEST 1
`define DDIM_CMD_FLUSH 3'h1
`define DDIM_CMD_WRITE 3'h2
`define DDIM_CMD_READ 3'h3
`define DDIM_CMD_SRST 3'h4
`define DDIM_ST_READY 0
`define DDIM_ST_ERROR 1
`define DDIM_ST_NONREC 2
`define DDIM_ST_BUSY 3
`define DDIM_ST_DIRTY 4
`define DDIM_ST_BUFFAIL 5
`define DDIM_ST_WFAULT 6
`define DDIM_ST_DONE 7
`define DDIM_ST_UNCORR 8
`endif

// [rtl/ddim_pkg.sv]
/*
 Types of the disk data integrity manager. Assumes the constants header.
*/
package ddim_pkg;
    typedef enum logic [3:0] {
        ST_BOOT, ST_BTEST_WR, ST_BTEST_RD, ST_IDLE, ST_WRITE, ST_WRETRY,
        ST_REMAP, ST_VERIFY, ST_READ, ST_FLUSH
    } ddim_state_type;
    typedef struct packed {
        logic off_track;
        logic shock;
        logic low_supply;
        logic spindle_bad;
        logic head_fault;
    } ddim_wmon_type;
    typedef struct packed {
        logic recal_done;
        logic spindle_ok;
        logic selfcheck_done;
    } ddim_rdy_type;
    typedef struct packed {
        logic done;
        logic fail;
        logic recovered;
        logic at_realloc_step;
    } ddim_media_type;
endpackage : ddim_pkg

// [rtl/ddim_top.sv]
/*
 Disk data integrity manager: sector ECC error accounting, buffer pattern test,
 write cache commit, ready and error status, write safety retry and reallocation.
 Assumes an APB master on pclk, media and servo conditions synchronous to pclk.
*/
// Design decisions made here: the APB register port and the address map.
// Function
// - Each sector carries a 52-byte ECC field over four interleaves.
// - First 4 ECC bytes are check bytes, other 48 are Reed-Solomon.
// - Twelve redundancy bytes belong to each interleave.
// - Up to 5 bad bytes per interleave, 20 per sector, fixed on the fly.
// - A byte with any wrong bit counts as one bad symbol.
// - Buffer test runs at reset and on host self-test request.
// - Buffer test writes and reads 00 and FF across all locations.
// - With cache on, writes complete while data is only buffered.
// - Reset or flush-type command commits cached data before completing.
// - Not-ready shown until recalibration, spindle speed and self-check done.
// - Once ready, spindle fault or write fault shows as error; code sets error on spindle loss only, write fault only pulses WFAULT.
// - Write monitors abort the write and start an automatic retry.
// - Errors left after full recovery are reported as non-recoverable.
// - Reallocations are never indicated to the host.
// - Failed write is remapped; error only if cache off and remap failed.
// - Failed read reports hard error and records a reallocation candidate.
// - Write to a candidate first verifies media, reallocates if it passes.
// - Read recovered at the set step reallocates, optionally after verify; code requests the remap at once, never after a verify.
`timescale 1ns/100ps
`include "ddim_consts.svh"
module ddim_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire ddim_pkg::ddim_rdy_type rdy_in,
    input wire ddim_pkg::ddim_wmon_type wmon_in,
    input wire ddim_pkg::ddim_media_type media_in,
    input wire logic sector_err_valid,
    input wire logic [23:0] sector_err_mask,
    output logic media_write_req,
    output logic media_read_req,
    output logic media_verify_req,
    output logic media_remap_req,
    output logic [31:0] media_lba
);
    // =====================================================================
    // Declarations
    logic [31:0] ctrl;
    logic [31:0] lba;
    logic [7:0] status;
    logic uncorr;
    logic [4:0] ecc_err_count;
    ddim_pkg::ddim_state_type state;
    logic [7:0] buf_mem [0:(1 << `DDIM_BUF_AW) - 1];
    logic [`DDIM_BUF_AW-1:0] buf_addr;
    logic pat_phase;
    logic selftest_go;
    logic [2:0] cmd_go;
    logic [3:0] retry_count;
    logic write_dirty;
    logic [31:0] cand_lba [0:`DDIM_CAND_N-1];
    logic [`DDIM_CAND_N-1:0] cand_valid;
    logic [`DDIM_CAND_IW-1:0] cand_wptr;
    logic cand_hit;
    logic [`DDIM_CAND_IW-1:0] cand_idx;
    logic apb_wr;
    logic apb_rd;
    logic boot_ready;
    logic [2:0] ilv_a, ilv_b, ilv_c, ilv_d;
    logic ilv_uncorr;
    logic wmon_trip;

    // =====================================================================
    // Helpers
    function automatic logic [2:0] ilv_count(input logic [23:0] m, input int lane);
        logic [2:0] c;
        c = 3'h0;
        for (int i = 0; i < 24; i++)
        begin
            if ((i % `DDIM_ILV_COUNT) == lane && m[i])
            begin
                c = c + 3'h1;
            end
        end
        return c;
    endfunction : ilv_count

    function automatic logic [7:0] test_pattern(input logic phase);
        return phase ? `DDIM_PAT_ONE : `DDIM_PAT_ZERO;
    endfunction : test_pattern

    assign apb_wr = psel && penable && pwrite;
    assign apb_rd = psel && !penable && !pwrite;
    assign boot_ready = rdy_in.recal_done && rdy_in.spindle_ok && rdy_in.selfcheck_done;
    assign wmon_trip = |wmon_in;

    // =====================================================================
    // Sector ECC accounting: a mask bit marks a byte with one or more bad bits
    always_comb
    begin
        ilv_a = ilv_count(sector_err_mask, 0);
        ilv_b = ilv_count(sector_err_mask, 1);
        ilv_c = ilv_count(sector_err_mask, 2);
        ilv_d = ilv_count(sector_err_mask, 3);
        ilv_uncorr = (ilv_a > `DDIM_MAX_ERR_ILV) || (ilv_b > `DDIM_MAX_ERR_ILV)
            || (ilv_c > `DDIM_MAX_ERR_ILV) || (ilv_d > `DDIM_MAX_ERR_ILV);
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ecc_err_count <= 5'h00;
            uncorr <= 1'b0;
        end
        else if (sector_err_valid)
        begin
            // Count is forced to the per-sector ceiling once any interleave is uncorrectable
            ecc_err_count <= ilv_uncorr ? `DDIM_MAX_ERR_SECTOR :
                5'(ilv_a) + 5'(ilv_b) + 5'(ilv_c) + 5'(ilv_d);
            uncorr <= ilv_uncorr;
        end
    end

    // =====================================================================
    // Register writes and command strobes
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            ctrl <= `DDIM_CTRL_RESET;
            lba <= 32'h0000_0000;
            selftest_go <= 1'b0;
            cmd_go <= 3'h0;
        end
        else
        begin
            selftest_go <= 1'b0;
            cmd_go <= 3'h0;
            if (apb_wr && paddr == `DDIM_OFF_CTRL)
            begin
                ctrl <= pwdata;
                selftest_go <= pwdata[`DDIM_CTRL_SELFTEST];
            end
            if (apb_wr && paddr == `DDIM_OFF_LBA)
            begin
                lba <= pwdata;
            end
            if (apb_wr && paddr == `DDIM_OFF_CMD)
            begin
                cmd_go <= pwdata[2:0];
            end
        end
    end

    // =====================================================================
    // APB read side, single-cycle answer
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end
        else
        begin
            pready <= psel && !penable;
            pslverr <= 1'b0;
            if (psel && !penable)
            begin
                case (paddr)
                    `DDIM_OFF_CTRL: prdata <= {ctrl[31:2], 1'b0, ctrl[`DDIM_CTRL_WCE]};
                    `DDIM_OFF_STATUS: prdata <= {23'h000000, uncorr, status};
                    `DDIM_OFF_ECCERR: prdata <= {27'h0000000, ecc_err_count};
                    `DDIM_OFF_LBA: prdata <= lba;
                    `DDIM_OFF_CMD: prdata <= 32'h0000_0000;
                    `DDIM_OFF_CNT: prdata <= 32'h0000_0000;
                    default:
                    begin
                        prdata <= 32'h0000_0000;
                        pslverr <= 1'b1;
                    end
                endcase
            end
        end
    end

    // =====================================================================
    // Candidate lookup
    always_comb
    begin
        cand_hit = 1'b0;
        cand_idx = '0;
        for (int i = 0; i < `DDIM_CAND_N; i++)
        begin
            if (cand_valid[i] && cand_lba[i] == lba)
            begin
                cand_hit = 1'b1;
                cand_idx = i[`DDIM_CAND_IW-1:0];
            end
        end
    end

    // =====================================================================
    // Buffer test memory
    always_ff @(posedge pclk)
    begin
        if (state == ddim_pkg::ST_BTEST_WR)
        begin
            buf_mem[buf_addr] <= test_pattern(pat_phase);
        end
    end

    // =====================================================================
    // Main sequencer
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            state <= ddim_pkg::ST_BOOT;
            buf_addr <= '0;
            pat_phase <= 1'b0;
            retry_count <= 4'h0;
            write_dirty <= 1'b0;
            cand_valid <= '0;
            cand_wptr <= '0;
            status[7:0] <= 8'h00;
            media_write_req <= 1'b0;
            media_read_req <= 1'b0;
            media_verify_req <= 1'b0;
            media_remap_req <= 1'b0;
            media_lba <= 32'h0000_0000;
        end
        else
        begin
            media_write_req <= 1'b0;
            media_read_req <= 1'b0;
            media_verify_req <= 1'b0;
            media_remap_req <= 1'b0;
            status[`DDIM_ST_DIRTY] <= write_dirty;
            status[`DDIM_ST_WFAULT] <= 1'b0;
            if (apb_rd && paddr == `DDIM_OFF_STATUS)
            begin
                status[`DDIM_ST_DONE] <= 1'b0;
            end
            // Spindle loss after ready turns into error status
            if (status[`DDIM_ST_READY] && !rdy_in.spindle_ok)
            begin
                status[`DDIM_ST_ERROR] <= 1'b1;
            end
            case (state)
                ddim_pkg::ST_BOOT:
                begin
                    // Not ready until boot conditions and buffer test end
                    status[`DDIM_ST_READY] <= 1'b0;
                    status[`DDIM_ST_BUSY] <= 1'b1;
                    buf_addr <= '0;
                    pat_phase <= 1'b0;
                    state <= ddim_pkg::ST_BTEST_WR;
                end
                ddim_pkg::ST_BTEST_WR:
                begin
                    buf_addr <= buf_addr + 1'b1;
                    if (buf_addr == `DDIM_BUF_LAST)
                    begin
                        state <= ddim_pkg::ST_BTEST_RD;
                    end
                end
                ddim_pkg::ST_BTEST_RD:
                begin
                    if (buf_mem[buf_addr] != test_pattern(pat_phase))
                    begin
                        status[`DDIM_ST_BUFFAIL] <= 1'b1;
                    end
                    buf_addr <= buf_addr + 1'b1;
                    if (buf_addr == `DDIM_BUF_LAST)
                    begin
                        pat_phase <= 1'b1;
                        state <= pat_phase ? ddim_pkg::ST_IDLE : ddim_pkg::ST_BTEST_WR;
                    end
                end
                ddim_pkg::ST_IDLE:
                begin
                    status[`DDIM_ST_READY] <= boot_ready;
                    status[`DDIM_ST_BUSY] <= !boot_ready;
                    retry_count <= 4'h0;
                    media_lba <= lba;
                    if (selftest_go)
                    begin
                        status[`DDIM_ST_BUFFAIL] <= 1'b0;
                        state <= ddim_pkg::ST_BOOT;
                    end
                    else if (boot_ready && cmd_go == `DDIM_CMD_WRITE)
                    begin
                        status[`DDIM_ST_BUSY] <= 1'b1;
                        if (ctrl[`DDIM_CTRL_WCE])
                        begin
                            // Completion ahead of the media write
                            write_dirty <= 1'b1;
                            status[`DDIM_ST_DONE] <= 1'b1;
                        end
                        if (cand_hit)
                        begin
                            media_verify_req <= 1'b1;
                            state <= ddim_pkg::ST_VERIFY;
                        end
                        else
                        begin
                            media_write_req <= 1'b1;
                            state <= ddim_pkg::ST_WRITE;
                        end
                    end
                    else if (boot_ready && cmd_go == `DDIM_CMD_READ)
                    begin
                        status[`DDIM_ST_BUSY] <= 1'b1;
                        media_read_req <= 1'b1;
                        state <= ddim_pkg::ST_READ;
                    end
                    else if (cmd_go == `DDIM_CMD_FLUSH || cmd_go == `DDIM_CMD_SRST)
                    begin
                        status[`DDIM_ST_BUSY] <= 1'b1;
                        state <= ddim_pkg::ST_FLUSH;
                    end
                end
                ddim_pkg::ST_WRITE:
                begin
                    if (wmon_trip)
                    begin
                        // Abort and retry the write
                        status[`DDIM_ST_WFAULT] <= 1'b1;
                        state <= ddim_pkg::ST_WRETRY;
                    end
                    else if (media_in.done)
                    begin
                        if (!media_in.fail)
                        begin
                            write_dirty <= 1'b0;
                            status[`DDIM_ST_DONE] <= 1'b1;
                            state <= ddim_pkg::ST_IDLE;
                        end
                        else
                        begin
                            state <= ddim_pkg::ST_WRETRY;
                        end
                    end
                end
                ddim_pkg::ST_WRETRY:
                begin
                    if (retry_count == `DDIM_RETRY_MAX)
                    begin
                        media_remap_req <= 1'b1;
                        state <= ddim_pkg::ST_REMAP;
                    end
                    else if (!wmon_trip)
                    begin
                        retry_count <= retry_count + 4'h1;
                        media_write_req <= 1'b1;
                        state <= ddim_pkg::ST_WRITE;
                    end
                end
                ddim_pkg::ST_REMAP:
                begin
                    if (media_in.done)
                    begin
                        write_dirty <= 1'b0;
                        if (media_in.fail && !ctrl[`DDIM_CTRL_WCE])
                        begin
                            status[`DDIM_ST_ERROR] <= 1'b1;
                            status[`DDIM_ST_NONREC] <= 1'b1;
                        end
                        status[`DDIM_ST_DONE] <= 1'b1;
                        state <= ddim_pkg::ST_IDLE;
                    end
                end
                ddim_pkg::ST_VERIFY:
                begin
                    if (media_in.done)
                    begin
                        if (!media_in.fail)
                        begin
                            media_remap_req <= 1'b1;
                            cand_valid[cand_idx] <= 1'b0;
                        end
                        // Write goes out a cycle after any remap request
                        state <= ddim_pkg::ST_WRETRY;
                    end
                end
                ddim_pkg::ST_READ:
                begin
                    if (media_in.done)
                    begin
                        status[`DDIM_ST_DONE] <= 1'b1;
                        state <= ddim_pkg::ST_IDLE;
                        if (media_in.fail)
                        begin
                            status[`DDIM_ST_ERROR] <= 1'b1;
                            status[`DDIM_ST_NONREC] <= 1'b1;
                            cand_lba[cand_wptr] <= lba;
                            cand_valid[cand_wptr] <= 1'b1;
                            cand_wptr <= cand_wptr + 1'b1;
                        end
                        else if (media_in.recovered && media_in.at_realloc_step)
                        begin
                            media_remap_req <= 1'b1;
                        end
                    end
                end
                ddim_pkg::ST_FLUSH:
                begin
                    if (!write_dirty)
                    begin
                        status[`DDIM_ST_DONE] <= 1'b1;
                        state <= ddim_pkg::ST_IDLE;
                    end
                    else
                    begin
                        media_write_req <= 1'b1;
                        state <= ddim_pkg::ST_WRITE;
                    end
                end
                default:
                begin
                    state <= ddim_pkg::ST_BOOT;
                end
            endcase
        end
    end
endmodule : ddim_top

// [bench/ddim_chk.sv]
/*
 Port checker of the integrity manager.
 Assumes a bind to ddim_top from the bench top file.
*/
`timescale 1ns/100ps
`include "ddim_consts.svh"
module ddim_chk (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic media_write_req,
    input wire logic media_read_req,
    input wire logic media_verify_req,
    input wire logic media_remap_req
);
    // ====
    // Port relations
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence s_access;
        psel && penable;
    endsequence
    sequence s_spare_rd;
        s_access ##0 (!pwrite && paddr == `DDIM_OFF_CNT);
    endsequence
    a_ready_access: assert property (s_access |-> pready)
        else $error("access without ready");
    a_ready_cause: assert property (pready |-> psel && penable)
        else $error("ready outside access");
    a_ready_pulse: assert property (pready |=> !pready)
        else $error("ready held");
    a_err_clean: assert property (pslverr |-> pready && prdata == 32'h0)
        else $error("error response not clean");
    a_spare_zero: assert property (s_spare_rd |-> prdata == 32'h0 && !pslverr)
        else $error("spare word not zero");
    a_write_pulse: assert property (media_write_req |=> !media_write_req)
        else $error("write request held");
    a_req_single: assert property ($onehot0({media_write_req, media_read_req,
        media_verify_req, media_remap_req}))
        else $error("two media requests");
    a_boot_quiet: assert property ($rose(presetn) |-> !(media_write_req || media_read_req)[*8])
        else $error("media access during buffer test");
endmodule : ddim_chk

// [bench/ddim_host_model.sv]
/*
 Host bus master of the integrity manager.
 Assumes the bench calls xfer and judges a hung transfer.
*/
`timescale 1ns/100ps
module ddim_host_model (
    input wire logic pclk,
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [11:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    // ====
    // Bus transfer
    initial
    begin
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
    end
    task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d,
        output logic [31:0] q, output logic e, output logic hung);
        hung = 1'b1;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (int i = 0; i < 16 && hung; i++)
        begin
            @(posedge pclk);
            if (pready === 1'b1)
            begin
                hung = 1'b0;
                q = prdata;
                e = pslverr;
            end
        end
        psel <= 1'b0;
        penable <= 1'b0;
        pwdata <= ~d;
    endtask : xfer
endmodule : ddim_host_model

// [bench/ddim_tb_top.sv]
/*
 Bench top of the integrity manager: host model, media responder, models.
 Assumes the design package, constants header and checker.
*/
`timescale 1ns/100ps
`include "ddim_consts.svh"
module ddim_tb_top;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel, penable, pwrite, pready, pslverr, e;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, q, r1, r2, media_lba;
    logic [31:0] lba = 32'h10;
    logic [23:0] m;
    ddim_pkg::ddim_rdy_type rdy_in = 3'h6;
    ddim_pkg::ddim_wmon_type wmon_in = '0;
    ddim_pkg::ddim_media_type media_in = '0;
    logic sector_err_valid = 1'b0;
    logic [23:0] sector_err_mask = 24'h0;
    logic media_write_req, media_read_req, media_verify_req, media_remap_req;
    logic trip = 1'b0;
    logic rd_fail = 1'b0;
    logic rd_recov = 1'b0;
    logic rm_fail = 1'b0;
    int error_cnt = 0;
    int n_tests = 0;
    int seed = 32'h9A7B;
    int lat = 60;
    int cnt = 0;
    int reqs[$];
    int cand[$];
    ddim_top i_ddim_top (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .rdy_in, .wmon_in, .media_in, .sector_err_valid,
        .sector_err_mask, .media_write_req, .media_read_req, .media_verify_req,
        .media_remap_req, .media_lba);
    ddim_host_model i_ddim_host_model (.pclk, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr);
    // ====
    // Clock, media responder, tasks
    initial
    begin
        forever #12.5 pclk = ~pclk;
    end
    always @(posedge pclk)
    begin
        media_in.done <= (cnt == 1);
        wmon_in.shock <= 1'b0;
        if (cnt > 0)
            cnt <= cnt - 1;
        if (media_write_req | media_read_req | media_verify_req | media_remap_req)
        begin
            reqs.push_back(int'({media_remap_req, media_verify_req, media_read_req,
                media_write_req}));
            media_in.fail <= (media_read_req & rd_fail) | (media_remap_req & rm_fail);
            media_in.recovered <= media_read_req & rd_recov;
            media_in.at_realloc_step <= media_read_req & rd_recov;
            if (media_write_req & trip)
                wmon_in.shock <= 1'b1;
            else
                cnt <= lat;
        end
    end
    task automatic end_of_test;
        $display("Comparisons %0d, mismatches %0d", n_tests, error_cnt);
        if (error_cnt == 0 && n_tests > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : end_of_test
    task automatic chk_val(input logic [31:0] got, input logic [31:0] exp);
        n_tests++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk_val
    task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
        logic hung;
        i_ddim_host_model.xfer(w, a, d, q, e, hung);
        if (hung)
        begin
            error_cnt++;
            end_of_test();
        end
    endtask : bus
    task automatic chk_st(input int b, input logic v);
        bus(1'b0, `DDIM_OFF_STATUS, 32'h0);
        chk_val({31'h0, q[b]}, {31'h0, v});
    endtask : chk_st
    task automatic wait_st(input int b, input logic v);
        for (int i = 0; i < 500; i++)
        begin
            bus(1'b0, `DDIM_OFF_STATUS, 32'h0);
            if (q[b] === v)
                return;
        end
        error_cnt++;
        end_of_test();
    endtask : wait_st
    task automatic cmd(input logic [31:0] c);
        bus(1'b0, `DDIM_OFF_STATUS, 32'h0);
        bus(1'b1, `DDIM_OFF_LBA, lba);
        bus(1'b1, `DDIM_OFF_CMD, c);
        wait_st(`DDIM_ST_DONE, 1'b1);
    endtask : cmd
    task automatic reset_dut;
        @(posedge pclk);
        presetn <= 1'b0;
        repeat (5) @(posedge pclk);
        presetn <= 1'b1;
    endtask : reset_dut
    function automatic int ecc_model(input logic [23:0] mk);
        int c[4] = '{0, 0, 0, 0};
        int t = 0;
        for (int n = 0; n < 24; n++)
            c[n % 4] += mk[n];
        foreach (c[k])
        begin
            if (c[k] > 5)
                return 20;
            t += c[k];
        end
        return t;
    endfunction : ecc_model
    // ====
    // Main sequence
    initial
    begin
        reset_dut();
        repeat (1100) @(posedge pclk);
        chk_st(`DDIM_ST_READY, 1'b0);
        rdy_in <= 3'h7;
        wait_st(`DDIM_ST_READY, 1'b1);
        chk_st(`DDIM_ST_BUFFAIL, 1'b0);
        bus(1'b0, `DDIM_OFF_CTRL, 32'h0);
        chk_val(q, `DDIM_CTRL_RESET);
        bus(1'b1, 12'hFFC, 32'hFFFF_FFFF);
        chk_val({31'h0, e}, 32'h1);
        bus(1'b0, 12'hFFC, 32'h0);
        chk_val(q, 32'h0);
        for (int i = 0; i < 20; i++)
        begin
            r1 = $random(seed);
            r2 = $random(seed);
            m = i[0] ? r1[23:0] : r1[23:0] & r2[23:0];
            if (i < 2)
                m = i[0] ? 24'hFFF0FF : 24'h111111;
            sector_err_mask <= m;
            sector_err_valid <= 1'b1;
            @(posedge pclk);
            sector_err_valid <= 1'b0;
            repeat (2) @(posedge pclk);
            bus(1'b0, `DDIM_OFF_ECCERR, 32'h0);
            chk_val(q, ecc_model(m));
        end
        cmd(`DDIM_CMD_WRITE);
        chk_st(`DDIM_ST_DIRTY, 1'b1);
        lat = 3;
        repeat (100) @(posedge pclk);
        cmd(`DDIM_CMD_FLUSH);
        cmd(`DDIM_CMD_FLUSH);
        chk_st(`DDIM_ST_DIRTY, 1'b0);
        reqs.delete();
        rd_recov = 1'b1;
        cmd(`DDIM_CMD_READ);
        repeat (100) @(posedge pclk);
        chk_val(reqs[$], 32'h8);
        chk_st(`DDIM_ST_ERROR, 1'b0);
        bus(1'b0, `DDIM_OFF_CNT, 32'h0);
        chk_val(q, 32'h0);
        rd_recov = 1'b0;
        reqs.delete();
        trip = 1'b1;
        rm_fail = 1'b1;
        cmd(`DDIM_CMD_WRITE);
        repeat (200) @(posedge pclk);
        chk_val(32'(reqs.size() > 2), 32'h1);
        chk_val(reqs[$], 32'h8);
        chk_st(`DDIM_ST_ERROR, 1'b0);
        rdy_in.spindle_ok <= 1'b0;
        repeat (3) @(posedge pclk);
        chk_st(`DDIM_ST_ERROR, 1'b1);
        rdy_in.spindle_ok <= 1'b1;
        reset_dut();
        wait_st(`DDIM_ST_READY, 1'b1);
        bus(1'b1, `DDIM_OFF_CTRL, 32'h0);
        cmd(`DDIM_CMD_WRITE);
        chk_st(`DDIM_ST_ERROR, 1'b1);
        reset_dut();
        wait_st(`DDIM_ST_READY, 1'b1);
        bus(1'b1, `DDIM_OFF_CTRL, 32'h0);
        trip = 1'b0;
        rd_fail = 1'b1;
        lba = $random(seed);
        cmd(`DDIM_CMD_READ);
        cand.push_back(lba);
        chk_val(media_lba, lba);
        chk_st(`DDIM_ST_NONREC, 1'b1);
        rd_fail = 1'b0;
        rm_fail = 1'b0;
        reqs.delete();
        cmd(`DDIM_CMD_WRITE);
        chk_val(reqs[0], (cand.size() > 0) ? 32'h4 : 32'h1);
        bus(1'b1, `DDIM_OFF_CTRL, 32'h3);
        @(posedge pclk);
        chk_st(`DDIM_ST_BUSY, 1'b1);
        wait_st(`DDIM_ST_BUSY, 1'b0);
        chk_st(`DDIM_ST_BUFFAIL, 1'b0);
        bus(1'b0, `DDIM_OFF_CTRL, 32'h0);
        chk_val(q, 32'h1);
        end_of_test();
    end
    initial
    begin
        repeat (60000) @(posedge pclk);
        error_cnt++;
        end_of_test();
    end
endmodule : ddim_tb_top
bind ddim_top ddim_chk i_ddim_chk (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .prdata, .pready, .pslverr, .media_write_req, .media_read_req, .media_verify_req,
    .media_remap_req);
